// ===== hdl/adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register byte offsets
`define OFS_ONESHOT_SELECT     8'h00
`define OFS_ONESHOT_RESULT     8'h04
`define OFS_PERIODIC_SELECT    8'h08
`define OFS_SLOT0_LIMIT        8'h0C
`define OFS_SLOT1_LIMIT        8'h10
`define OFS_PERIODIC_CONTROL   8'h14
`define OFS_CONVERTER_CONTROL  8'h18
`define OFS_SLOT0_RESULT       8'h1C
`define OFS_SLOT1_RESULT       8'h20
`define OFS_STATUS             8'h24

// Field positions
`define ONESHOT_START_BIT      4
`define LIMIT_POLARITY_BIT     12
`define SLOT0_EN_BIT           16
`define SLOT1_EN_BIT           17
`define SLOT0_OFF_BIT          18
`define SLOT1_OFF_BIT          19
`define FORCE_ON_BIT           0
`define EXT_DELAY_BIT          1
`define SLEEP_BIT              2
`define THERM_EN_BIT           3

// Reset values
`define INTERVAL_RESET         16'h0000
`define THERM_EN_RESET         1'b1

// Timing
`define CLK_HZ                 25000000
`define EXT_DELAY_US           400
// Scaled in two steps so the product stays inside 32 bits
`define EXT_DELAY_CYCLES       ((`EXT_DELAY_US * (`CLK_HZ / 1000)) / 1000)
`define SETTLE_CYCLES          8
`define MAX_SLEEP_CHANNEL      10
`define THERM_CH_A             12
`define THERM_CH_B             13

`endif

// ===== hdl/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_powerup,
    st_wait,
    st_convert,
    st_store
  } seq_state_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic [11:0] value;
    logic        above;
  } limit_s;

endpackage

// ===== hdl/adc_conversion_sequencer.sv
`timescale 1ns/10ps
`include "adc_seq_regs.svh"

// Operation
// - One-shot: select channel, request; result goes to result reg, event raised
// - Periodic mode converts one or two slots, compares against limits
// - Periodic mode powers converter up and down by itself
// - Each periodic result lands in its slot result register
// - Slots converted in ascending channel order; lower result to slot 0
// - Limit hit raises interrupt and stores the result
// - Unread results are overwritten by newer ones
// - Periodic conversions continue regardless of pending events
// - Limit hit with slot power-off enable requests shutdown
// - Sleep/off converts only channels 0-10, plus 12/13 if thermal on
// - Pending one-shot request beats periodic conversion
// - Extended-delay bit adds 400 us before sampling
// - Results are 12-bit unsigned codes 0 to 4095
module adc_conversion_sequencer #(
  parameter int unsigned EXT_DELAY = `EXT_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Register bus
  input  wire adc_seq_pkg::axi_req_s axi_req,
  output      adc_seq_pkg::axi_rsp_s axi_rsp,
  // Converter core
  output      logic                 adc_power,
  output      logic                 adc_start,
  output      logic [3:0]           adc_channel,
  input  wire logic                 adc_done,
  input  wire logic [11:0]          adc_code,
  // Device state
  input  wire logic                 low_power_state,
  // System events
  output      logic                 conv_event,
  output      logic                 shutdown_request
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    adc_seq_pkg::axi_rsp_s   rsp;
    logic                    aw_held;
    logic [7:0]              aw_addr;
    logic                    w_held;
    logic [31:0]             w_data;
    logic [3:0]              os_channel;
    logic                    os_pending;
    logic [11:0]             os_result;
    logic [3:0]              sel0;
    logic [3:0]              sel1;
    adc_seq_pkg::limit_s     lim0;
    adc_seq_pkg::limit_s     lim1;
    logic [15:0]             interval;
    logic                    en0;
    logic                    en1;
    logic                    off0;
    logic                    off1;
    logic                    force_on;
    logic                    ext_delay;
    logic                    therm_en;
    logic [11:0]             res0;
    logic [11:0]             res1;
    logic                    hit0;
    logic                    hit1;
    logic                    os_done;
    logic [15:0]             tick;
    logic                    per_pending;
    logic                    per_stage;
    logic                    cur_oneshot;
    logic                    cur_slot;
    logic [19:0]             wait_cnt;
    logic [11:0]             code;
    adc_seq_pkg::seq_state_e state;
    logic                    power;
    logic                    start;
    logic [3:0]              channel;
    logic                    irq;
    logic                    shutdown;
  } state_s;

  state_s cur;
  state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////

  // Low-power channel filter
  function automatic logic channel_allowed(input logic [3:0] ch,
                                           input logic       low_pwr,
                                           input logic       therm);
    if (!low_pwr)
      channel_allowed = 1'b1;
    else if (ch <= 4'(`MAX_SLEEP_CHANNEL))
      channel_allowed = 1'b1;
    else if (ch == 4'(`THERM_CH_A) || ch == 4'(`THERM_CH_B))
      channel_allowed = therm;
    else
      channel_allowed = 1'b0;
  endfunction

  function automatic logic limit_hit(input logic [11:0]         code,
                                     input adc_seq_pkg::limit_s lim);
    limit_hit = lim.above ? (code > lim.value) : (code < lim.value);
  endfunction

  function automatic logic [31:0] read_word(input state_s s,
                                            input logic [7:0] a);
    case (a)
      `OFS_ONESHOT_SELECT:
        read_word = {27'h0000000, s.os_pending, s.os_channel};
      `OFS_ONESHOT_RESULT:    read_word = {20'h00000, s.os_result};
      `OFS_PERIODIC_SELECT:   read_word = {24'h000000, s.sel1, s.sel0};
      `OFS_SLOT0_LIMIT:
        read_word = {19'h00000, s.lim0.above, s.lim0.value};
      `OFS_SLOT1_LIMIT:
        read_word = {19'h00000, s.lim1.above, s.lim1.value};
      `OFS_PERIODIC_CONTROL:
        read_word = {12'h000, s.off1, s.off0, s.en1, s.en0, s.interval};
      `OFS_CONVERTER_CONTROL:
        read_word = {28'h0000000, s.therm_en, 1'b0, s.ext_delay,
                     s.force_on};
      `OFS_SLOT0_RESULT:      read_word = {20'h00000, s.res0};
      `OFS_SLOT1_RESULT:      read_word = {20'h00000, s.res1};
      `OFS_STATUS:
        read_word = {26'h0000000, s.shutdown, s.power, s.hit1, s.hit0,
                     s.os_done, s.state != adc_seq_pkg::st_idle};
      default:                read_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic       do_write;
    logic [7:0] wa;
    logic       trigger;
    logic [3:0] lo_ch;
    logic [3:0] hi_ch;
    logic       lo_slot;
    logic       slot_en;
    logic       hit;
    next_cur = cur;
    do_write = 1'b0;
    wa       = cur.aw_addr;
    trigger  = 1'b0;
    lo_ch    = 4'h0;
    hi_ch    = 4'h0;
    lo_slot  = 1'b0;
    slot_en  = 1'b0;
    hit      = 1'b0;
    next_cur.start = 1'b0;
    next_cur.irq   = 1'b0;

    // Write channel: address and data in either order
    if (axi_req.awvalid && cur.rsp.awready)
    begin
      next_cur.aw_held     = 1'b1;
      next_cur.aw_addr     = axi_req.awaddr;
      next_cur.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && cur.rsp.wready)
    begin
      next_cur.w_held     = 1'b1;
      next_cur.w_data     = axi_req.wdata;
      next_cur.rsp.wready = 1'b0;
    end
    if (cur.aw_held && cur.w_held && !cur.rsp.bvalid)
    begin
      do_write            = 1'b1;
      next_cur.aw_held    = 1'b0;
      next_cur.w_held     = 1'b0;
      next_cur.rsp.bvalid = 1'b1;
      next_cur.rsp.bresp  = mapped(wa) ? 2'h0 : 2'h2;
    end
    if (cur.rsp.bvalid && axi_req.bready)
    begin
      next_cur.rsp.bvalid  = 1'b0;
      next_cur.rsp.awready = 1'b1;
      next_cur.rsp.wready  = 1'b1;
    end

    // Read channel
    if (axi_req.arvalid && cur.rsp.arready)
    begin
      next_cur.rsp.arready = 1'b0;
      next_cur.rsp.rvalid  = 1'b1;
      next_cur.rsp.rdata   = read_word(cur, axi_req.araddr);
      next_cur.rsp.rresp   = mapped(axi_req.araddr) ? 2'h0 : 2'h2;
    end
    if (cur.rsp.rvalid && axi_req.rready)
    begin
      next_cur.rsp.rvalid  = 1'b0;
      next_cur.rsp.arready = 1'b1;
    end

    // Register writes; status flags os_done, hit0, hit1 and shutdown clear by writing one
    if (do_write)
    begin
      unique case (wa)
        `OFS_ONESHOT_SELECT:
        begin
          next_cur.os_channel = cur.w_data[3:0];
          if (cur.w_data[`ONESHOT_START_BIT])
            next_cur.os_pending = 1'b1;
        end
        `OFS_PERIODIC_SELECT:
        begin
          next_cur.sel0 = cur.w_data[3:0];
          next_cur.sel1 = cur.w_data[7:4];
        end
        `OFS_SLOT0_LIMIT:
          next_cur.lim0 = {cur.w_data[11:0], cur.w_data[`LIMIT_POLARITY_BIT]};
        `OFS_SLOT1_LIMIT:
          next_cur.lim1 = {cur.w_data[11:0], cur.w_data[`LIMIT_POLARITY_BIT]};
        `OFS_PERIODIC_CONTROL:
        begin
          next_cur.interval = cur.w_data[15:0];
          next_cur.en0      = cur.w_data[`SLOT0_EN_BIT];
          next_cur.en1      = cur.w_data[`SLOT1_EN_BIT];
          next_cur.off0     = cur.w_data[`SLOT0_OFF_BIT];
          next_cur.off1     = cur.w_data[`SLOT1_OFF_BIT];
          next_cur.tick     = cur.w_data[15:0];
        end
        `OFS_CONVERTER_CONTROL:
        begin
          next_cur.force_on  = cur.w_data[`FORCE_ON_BIT];
          next_cur.ext_delay = cur.w_data[`EXT_DELAY_BIT];
          next_cur.therm_en  = cur.w_data[`THERM_EN_BIT];
        end
        `OFS_STATUS:
        begin
          if (cur.w_data[1])
            next_cur.os_done = 1'b0;
          if (cur.w_data[2])
            next_cur.hit0 = 1'b0;
          if (cur.w_data[3])
            next_cur.hit1 = 1'b0;
          if (cur.w_data[5])
            next_cur.shutdown = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Interval counter; keeps running whatever flags are pending
    if (cur.en0 || cur.en1)
    begin
      if (cur.tick == 16'h0000)
      begin
        trigger       = 1'b1;
        next_cur.tick = cur.interval;
      end
      else
        next_cur.tick = cur.tick - 16'h0001;
    end
    if (trigger)
      next_cur.per_pending = 1'b1;

    // Ascending channel order across the two slots
    lo_slot = (cur.en0 && cur.en1) ? (cur.sel1 < cur.sel0) : cur.en1;
    lo_ch   = lo_slot ? cur.sel1 : cur.sel0;
    hi_ch   = lo_slot ? cur.sel0 : cur.sel1;

    // Sequencer
    unique case (cur.state)
      adc_seq_pkg::st_idle:
      begin
        next_cur.power = cur.force_on;
        // One-shot first; a mid-conversion request waits here
        if (cur.os_pending &&
            channel_allowed(cur.os_channel, low_power_state, cur.therm_en))
        begin
          next_cur.cur_oneshot = 1'b1;
          next_cur.os_pending  = 1'b0;
          next_cur.channel     = cur.os_channel;
          next_cur.state       = adc_seq_pkg::st_powerup;
        end
        else if (cur.per_pending)
        begin
          slot_en = cur.per_stage ? (cur.en0 && cur.en1) : 1'b1;
          if (!slot_en || !(cur.en0 || cur.en1))
          begin
            next_cur.per_pending = 1'b0;
            next_cur.per_stage   = 1'b0;
          end
          else
          begin
            next_cur.cur_oneshot = 1'b0;
            // Lower channel always lands in slot 0 when both run
            next_cur.cur_slot    = (cur.en0 && cur.en1) ? cur.per_stage
                                                        : lo_slot;
            next_cur.channel     = cur.per_stage ? hi_ch : lo_ch;
            if (channel_allowed(next_cur.channel, low_power_state,
                                cur.therm_en))
              next_cur.state = adc_seq_pkg::st_powerup;
            else
            begin
              next_cur.per_stage   = ~cur.per_stage && cur.en0 && cur.en1;
              next_cur.per_pending = next_cur.per_stage;
            end
          end
        end
        else if (cur.os_pending)
          next_cur.os_pending = 1'b0;
      end
      adc_seq_pkg::st_powerup:
      begin
        next_cur.power    = 1'b1;
        next_cur.wait_cnt = cur.ext_delay ?
          20'(EXT_DELAY + `SETTLE_CYCLES) : 20'(`SETTLE_CYCLES);
        next_cur.state    = adc_seq_pkg::st_wait;
      end
      adc_seq_pkg::st_wait:
      begin
        if (cur.wait_cnt <= 20'h00001)
        begin
          next_cur.start = 1'b1;
          next_cur.state = adc_seq_pkg::st_convert;
        end
        else
          next_cur.wait_cnt = cur.wait_cnt - 20'h00001;
      end
      adc_seq_pkg::st_convert:
        if (adc_done)
        begin
          // Code is only valid alongside done
          next_cur.code  = adc_code;
          next_cur.state = adc_seq_pkg::st_store;
        end
      adc_seq_pkg::st_store:
      begin
        next_cur.state = adc_seq_pkg::st_idle;
        next_cur.power = cur.force_on;
        if (cur.cur_oneshot)
        begin
          next_cur.os_result = cur.code;
          next_cur.os_done   = 1'b1;
          next_cur.irq       = 1'b1;
        end
        else
        begin
          hit = limit_hit(cur.code, cur.cur_slot ? cur.lim1 : cur.lim0);
          if (cur.cur_slot)
            next_cur.res1 = cur.code;
          else
            next_cur.res0 = cur.code;
          if (hit)
          begin
            next_cur.irq = 1'b1;
            if (cur.cur_slot)
              next_cur.hit1 = 1'b1;
            else
              next_cur.hit0 = 1'b1;
            if (cur.cur_slot ? cur.off1 : cur.off0)
              next_cur.shutdown = 1'b1;
          end
          next_cur.per_stage   = ~cur.per_stage && cur.en0 && cur.en1;
          next_cur.per_pending = next_cur.per_stage || trigger;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cur             <= '0;
      cur.rsp.awready <= 1'b1;
      cur.rsp.wready  <= 1'b1;
      cur.rsp.arready <= 1'b1;
      cur.interval    <= `INTERVAL_RESET;
      cur.therm_en    <= `THERM_EN_RESET;
      cur.state       <= adc_seq_pkg::st_idle;
    end
    else
      cur <= next_cur;
  end

  assign axi_rsp          = cur.rsp;
  assign adc_power        = cur.power;
  assign adc_start        = cur.start;
  assign adc_channel      = cur.channel;
  assign conv_event       = cur.irq;
  assign shutdown_request = cur.shutdown;

endmodule

// ===== test/adc_core_model.sv
`timescale 1ns/10ps
module adc_core_model (
  // Clock
  input  wire logic        sys_clk,
  // Control from sequencer; slow comes from the testbench
  input  wire logic        adc_power,
  input  wire logic        adc_start,
  input  wire logic [3:0]  adc_channel,
  input  wire logic        slow,
  // Result to sequencer
  output      logic        adc_done,
  output      logic [11:0] adc_code
);
  int         cnt = 0;
  logic [3:0] ch = 4'h0;

  initial
  begin
    adc_done = 1'b0;
    adc_code = 12'hAAA;
  end

  ////////////////////////////////////////////////////////////////////////
  // Code hangs on the channel only; stale data toggles every cycle
  always @(posedge sys_clk)
  begin
    adc_done <= 1'b0;
    adc_code <= ~adc_code;
    if (cnt > 0)
      cnt <= cnt - 1;
    if (adc_start && adc_power)
    begin
      cnt <= slow ? 12 : 2;
      ch  <= adc_channel;
    end
    else if (cnt == 1)
    begin
      adc_done <= 1'b1;
      adc_code <= {ch, 8'h3C};
    end
  end
endmodule

// ===== test/adc_seq_sva.sv
`timescale 1ns/10ps
module adc_seq_sva #(
  parameter int unsigned EXT_DELAY = 4
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // Register bus
  input  wire adc_seq_pkg::axi_req_s axi_req,
  input  wire adc_seq_pkg::axi_rsp_s axi_rsp,
  // Converter core
  input  wire logic                  adc_power,
  input  wire logic                  adc_start,
  input  wire logic [3:0]            adc_channel,
  input  wire logic                  adc_done,
  input  wire logic [11:0]           adc_code,
  // Device state and events
  input  wire logic                  low_power_state,
  input  wire logic                  conv_event,
  input  wire logic                  shutdown_request
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  logic [3:0] since_done;

  // Saturating age of the last converter result
  always_ff @(posedge sys_clk)
  begin
    if (reset || adc_done)
      since_done <= 4'h0;
    else if (since_done != 4'hF)
      since_done <= since_done + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence both_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence read_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  a_start_power: assert property (adc_start |-> adc_power)
    else $error("start without converter power");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  a_settle_gap: assert property ($rose(adc_power) |->
    !adc_start [*7])
    else $error("start before settling time");
  a_sleep_channel: assert property (adc_start && low_power_state |->
    adc_channel <= 4'hA || adc_channel == 4'hC || adc_channel == 4'hD)
    else $error("forbidden channel in low power");
  a_event_cause: assert property (conv_event |->
    since_done <= 4'h3)
    else $error("event without fresh result");
  a_event_single: assert property (conv_event |=> !conv_event)
    else $error("event longer than one cycle");
  a_shutdown_cause: assert property ($rose(shutdown_request) |->
    since_done <= 4'h3)
    else $error("shutdown without fresh result");
  a_write_answer: assert property (both_taken |->
    ##[1:3] axi_rsp.bvalid)
    else $error("write response missing");
  a_read_answer: assert property (read_taken |=> axi_rsp.rvalid)
    else $error("read data late");
  a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
endmodule

bind adc_conversion_sequencer adc_seq_sva #(
  .EXT_DELAY(EXT_DELAY)
) i_adc_seq_sva (
  .sys_clk(sys_clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .adc_power(adc_power), .adc_start(adc_start), .adc_channel(adc_channel),
  .adc_done(adc_done), .adc_code(adc_code),
  .low_power_state(low_power_state), .conv_event(conv_event),
  .shutdown_request(shutdown_request)
);

// ===== test/tb_adc_conversion_sequencer.sv
`timescale 1ns/10ps
module tb_adc_conversion_sequencer;
  logic                  sys_clk;
  logic                  reset;
  adc_seq_pkg::axi_req_s req;
  adc_seq_pkg::axi_rsp_s rsp;
  logic                  adc_power;
  logic                  adc_start;
  logic [3:0]            adc_channel;
  logic                  adc_done;
  logic [11:0]           adc_code;
  logic                  low_power_state;
  logic                  conv_event;
  logic                  shutdown_request;
  logic                  slow;
  logic [31:0]           d;
  logic [1:0]            r;
  logic [3:0]            chq[$];
  int                    fail_count = 0;
  int                    n_checks = 0;
  int                    evt_cnt = 0;
  int                    pw_cnt = 0;
  int                    gap = 0;
  int                    base;
  int                    n;

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  adc_conversion_sequencer #(
    .EXT_DELAY(4)
  ) i_adc_conversion_sequencer (
    .sys_clk(sys_clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .adc_power(adc_power), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_code(adc_code),
    .low_power_state(low_power_state), .conv_event(conv_event),
    .shutdown_request(shutdown_request)
  );

  adc_core_model i_adc_core_model (
    .sys_clk(sys_clk), .adc_power(adc_power), .adc_start(adc_start),
    .adc_channel(adc_channel), .slow(slow), .adc_done(adc_done),
    .adc_code(adc_code)
  );

  // Power-up age at each start, start order and event count
  always @(posedge sys_clk)
  begin
    pw_cnt <= adc_power ? pw_cnt + 1 : 0;
    if (adc_start)
    begin
      gap <= pw_cnt;
      chq.push_back(adc_channel);
    end
    if (conv_event)
      evt_cnt <= evt_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Leading edge keeps a released ready from being raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
    wr(a, v);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    rd(a);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic oneshot(input logic [3:0] ch, input logic ev);
    n = evt_cnt;
    wchk(8'h00, {27'h0, 1'b1, ch}, 2'h0);
    for (int i = 0; i < 60 && evt_cnt == n; i++)
      @(posedge sys_clk);
    chk(evt_cnt - n, {31'h0, ev});
  endtask

  // Two-point correction in 1/1024 fixed point
  function automatic int corrected(input int a, input int d1, input int d2);
    int k;
    int b;
    k = 1024 + ((d2 - d1) * 1024) / (3112 - 2064);
    b = d1 - ((k - 1024) * 2064) / 1024;
    corrected = ((a - b) * 1024) / k;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(40 * 20000);
    fail_count++;
    $display("mismatch at %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    reset = 1'b1;
    req = '0;
    low_power_state = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(8'h18, 32'h0000_0008, 2'h0);
    rchk(8'h14, 32'h0000_0000, 2'h0);
    rchk(8'h28, 32'h0000_0000, 2'h2);
    wchk(8'h28, 32'h0000_0001, 2'h2);
    $display("test registers done");
    // First result after reset is not trusted
    oneshot(4'h0, 1'b1);
    oneshot(4'h2, 1'b1);
    rchk(8'h04, 32'h0000_023C, 2'h0);
    chk(corrected(d[11:0], 8, 8), 32'h0000_0234);
    base = gap;
    wchk(8'h18, 32'h0000_000A, 2'h0);
    oneshot(4'h7, 1'b1);
    chk(gap, base + 4);
    wchk(8'h18, 32'h0000_0008, 2'h0);
    $display("test one-shot done");
    // Slot 0 limit uses below polarity and never trips
    wchk(8'h0C, 32'h0000_0100, 2'h0);
    wchk(8'h10, 32'h0000_1000, 2'h0);
    // Higher channel in slot 0 on purpose to exercise the ordering
    wchk(8'h08, 32'h0000_0016, 2'h0);
    chq.delete();
    slow = 1'b1;
    n = evt_cnt;
    wchk(8'h14, 32'h000B_003C, 2'h0);
    repeat (400) @(posedge sys_clk);
    chk(chq.size() >= 4, 1);
    chk(chq[0], 4'h1);
    chk(chq[1], 4'h6);
    chk(chq[2], 4'h1);
    chk(evt_cnt - n >= 2, 1);
    chk(shutdown_request, 1'b1);
    rchk(8'h1C, 32'h0000_013C, 2'h0);
    rchk(8'h20, 32'h0000_063C, 2'h0);
    rd(8'h24);
    chk({d[5], d[3:2]}, 3'h6);
    wchk(8'h18, 32'h0000_0009, 2'h0);
    wchk(8'h14, 32'h0000_0000, 2'h0);
    repeat (2500) @(posedge sys_clk);
    wchk(8'h18, 32'h0000_0008, 2'h0);
    wchk(8'h24, 32'h0000_003E, 2'h0);
    @(posedge sys_clk);
    chk(shutdown_request, 1'b0);
    $display("test periodic done");
    slow = 1'b0;
    low_power_state <= 1'b1;
    oneshot(4'hB, 1'b0);
    oneshot(4'hC, 1'b1);
    rchk(8'h04, 32'h0000_0C3C, 2'h0);
    wchk(8'h18, 32'h0000_0000, 2'h0);
    oneshot(4'hD, 1'b0);
    oneshot(4'hA, 1'b1);
    low_power_state <= 1'b0;
    $display("test low power done");
    end_sim();
  end
endmodule
